// file: hdl/mss_scheduler.sv
// Idle-time media scan, pre-scan, deferred reallocation and read-back scheduler
//
// Notes on behaviour
// R1 - Idle drive scans whole media sequentially
// R2 - First scan starts after 5 ms idle
// R3 - Later scans start after 500 ms idle
// R4 - Scan bursts 800 ms, then 100 ms pause
// R5 - Host command stops scan read at once
// R6 - Own error recovery finishes before host
// R7 - Only first interrupting command pays 1 ms
// R8 - Scan errors logged or reallocated per enables
// R9 - Pre-scan enabled out of reset
// R10 - Pre-scan: unscanned writes become write-verify
// R11 - Pre-scan: scanning starts immediately when idle
// R12 - Pre-scan off after 24 power-on hours
// R13 - Unreadable drive reads mark deferred reallocation
// R14 - Marked write: rewrite, verify, remap on fail
// R15 - Both enables clear: error sense, no realloc
// R16 - Idle read-back compares against buffered write data
// R17 - Read-back mismatch: rewrite, verify, remap
// R18 - Reallocation needs enable set, continuous-read clear
// R19 - Idle only without host command; restart timer
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "mss_defines.svh"
module mss_scheduler import mss_pkg::*; #(
  parameter int LBA_W = 10,
  parameter int CLK_HZ = 20000000,
  parameter int CYC_PER_MS = CLK_HZ / 1000,
  parameter int MS_PER_HOUR = 3600000
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic INT_O,
  // Host command path
  input wire logic HOST_BUSY_I,
  output logic HOST_GO_O,
  input wire logic WR_CMD_I,
  input wire logic [LBA_W-1:0] WR_LBA_I,
  output logic WR_DONE_O,
  output logic WR_VERIFY_O,
  output logic WR_DAR_O,
  output logic WR_ERR_O,
  input wire logic HOST_RD_BAD_I,
  input wire logic [LBA_W-1:0] HOST_RD_LBA_I,
  // Media channel
  output logic MED_RD_REQ_O,
  output logic [LBA_W-1:0] MED_LBA_O,
  input wire logic MED_RD_DONE_I,
  input wire logic [1:0] MED_RD_STAT_I,
  input wire logic MED_RECOV_I,
  input wire logic VFY_FAIL_I,
  input wire logic [LBA_W-1:0] VFY_LBA_I,
  output logic REMAP_O,
  output logic [LBA_W-1:0] REMAP_LBA_O,
  // Idle read-back
  input wire logic IDLE_VERIFY_AFTER_WRITE_PEND_I,
  output logic IDLE_VERIFY_AFTER_WRITE_RD_O,
  input wire logic IDLE_VERIFY_AFTER_WRITE_DONE_I,
  input wire logic IDLE_VERIFY_AFTER_WRITE_MISMATCH_I,
  input wire logic [LBA_W-1:0] IDLE_VERIFY_AFTER_WRITE_LBA_I,
  output logic RWR_O,
  output logic [LBA_W-1:0] RWR_LBA_O
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic mss_hit(input logic [7:0] a, input logic [7:0] off);
    mss_hit = (a[7:2] == off[7:2]);
  endfunction : mss_hit

  mss_state_t state, next_state;
  logic [`MSS_CTRL_W-1:0] ctrl;
  logic prescan, first_done;
  logic [14:0] pre_ms;
  logic ms_tick;
  logic [21:0] pre_hr;
  logic [4:0] hours;
  logic [9:0] tmr, idle_ms, start_dly;
  logic [LBA_W-1:0] scan_ptr, init_cnt, log_lba, wr_lba_p1;
  logic wr_p1, mark, wr_scanned, rd_ok, wr_ok;
  logic scan_done, scan_bad, scan_realloc;
  logic [`MSS_EV_W-1:0] istat, imask, ev;
  logic a_wr, a_rd;
  logic [7:0] a_addr;
  logic mem_we, mem_wd;
  logic [LBA_W-1:0] mem_wa;
  logic [31:0] rd_mux;

  assign rd_ok = ctrl[`MSS_C_AUTO_READ_REALLOCATE_ENABLE] & ~ctrl[`MSS_C_RC]; // R18
  assign wr_ok = ctrl[`MSS_C_AUTO_WRITE_REALLOCATE_ENABLE] & ~ctrl[`MSS_C_RC]; // R18

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick enable
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || ms_tick) begin
      pre_ms <= 15'h0000;
    end else begin
      pre_ms <= pre_ms + 15'h0001;
    end
  end
  assign ms_tick = (pre_ms == 15'(CYC_PER_MS - 1));

  // Power-on hours, saturating
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      pre_hr <= 22'h000000;
      hours <= 5'h00;
    end else if (ms_tick) begin
      if (pre_hr == 22'(MS_PER_HOUR - 1)) begin
        pre_hr <= 22'h000000;
        if (hours != `MSS_HOURS_MAX) begin
          hours <= hours + 5'h01;
        end
      end else begin
        pre_hr <= pre_hr + 22'h000001;
      end
    end
  end

  // Idle timer, cleared by any host command
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || HOST_BUSY_I) begin
      idle_ms <= 10'h000; // R19
    end else if (ms_tick && idle_ms != `MSS_IDLE_MAX_MS) begin
      idle_ms <= idle_ms + 10'h001;
    end
  end

  // Idle start delay selection
  always_comb begin
    if (prescan) begin
      start_dly = `MSS_START_NOW_MS; // R11
    end else if (first_done) begin
      start_dly = `MSS_START_LATER_MS; // R3
    end else begin
      start_dly = `MSS_START_FIRST_MS; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scan state machine
  always_comb begin
    next_state = state;
    case (state)
      MSS_S_INIT: begin
        if (init_cnt == {LBA_W{1'b1}}) next_state = MSS_S_IDLE;
      end
      MSS_S_IDLE: begin
        if (ctrl[`MSS_C_SCAN_EN] && !HOST_BUSY_I && idle_ms >= start_dly) begin
          next_state = MSS_S_READ; // R1 R19
        end
      end
      MSS_S_READ: begin
        if (MED_RECOV_I) begin
          next_state = MSS_S_READ; // R6
        end else if (HOST_BUSY_I) begin
          next_state = MSS_S_RET; // R5 R7
        end else if (scan_done && scan_ptr == {LBA_W{1'b1}}) begin
          next_state = MSS_S_IDLE;
        end else if (tmr >= `MSS_BURST_MS || !ctrl[`MSS_C_SCAN_EN]) begin
          next_state = MSS_S_SUSP; // R4
        end
      end
      MSS_S_SUSP: begin
        if (HOST_BUSY_I || !ctrl[`MSS_C_SCAN_EN]) begin
          next_state = MSS_S_IDLE;
        end else if (tmr >= `MSS_SUSP_MS) begin
          next_state = MSS_S_READ; // R4
        end
      end
      MSS_S_RET: begin
        if (tmr >= `MSS_OVH_MS) next_state = MSS_S_IDLE; // R7
      end
      default: next_state = MSS_S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      state <= MSS_S_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Time in state, in ms
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || next_state != state) begin
      tmr <= 10'h000;
    end else if (ms_tick && tmr != `MSS_IDLE_MAX_MS) begin
      tmr <= tmr + 10'h001;
    end
  end

  // Mark memory clearing sweep after reset
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      init_cnt <= '0;
    end else if (state == MSS_S_INIT) begin
      init_cnt <= init_cnt + {{(LBA_W-1){1'b0}}, 1'b1};
    end
  end

  // Handshakes toward host path, media and read-back engine
  assign HOST_GO_O = HOST_BUSY_I && state != MSS_S_READ && state != MSS_S_RET
                     && state != MSS_S_INIT; // R7
  assign MED_RD_REQ_O = (state == MSS_S_READ) && (!HOST_BUSY_I || MED_RECOV_I); // R5 R6
  assign MED_LBA_O = scan_ptr;
  assign IDLE_VERIFY_AFTER_WRITE_RD_O = ctrl[`MSS_C_IDLE_VERIFY_AFTER_WRITE_EN] && IDLE_VERIFY_AFTER_WRITE_PEND_I && !HOST_BUSY_I
                     && (state == MSS_S_IDLE || state == MSS_S_SUSP); // R16

  ////////////////////////////////////////////////////////////////////////////////
  // Scan progress
  assign scan_done = (state == MSS_S_READ) && MED_RD_DONE_I && MED_RD_REQ_O;
  assign scan_bad = scan_done && (MED_RD_STAT_I != MSS_RD_OK);
  assign scan_realloc = scan_bad && rd_ok; // R8

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      scan_ptr <= '0;
    end else if (scan_done) begin
      scan_ptr <= scan_ptr + {{(LBA_W-1){1'b0}}, 1'b1}; // R1
    end
  end

  // Last failing scan site, for software
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      log_lba <= '0;
    end else if (scan_bad) begin
      log_lba <= scan_ptr; // R8
    end
  end

  // First pass flag and pre-scan enable
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      prescan <= 1'b1; // R9
      first_done <= 1'b0;
    end else begin
      if (scan_done && scan_ptr == {LBA_W{1'b1}}) begin
        first_done <= 1'b1;
        prescan <= 1'b0;
      end else if (prescan && hours >= `MSS_PRESCAN_HOURS) begin
        prescan <= 1'b0; // R12
      end else if (a_wr && mss_hit(a_addr, `MSS_OFF_CTRL)) begin
        prescan <= HWDATA_I[`MSS_C_PRESCAN];
        first_done <= HWDATA_I[`MSS_C_FIRST_DONE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mark memory write selection
  always_comb begin
    mem_we = 1'b1;
    mem_wa = scan_ptr;
    mem_wd = 1'b1;
    if (state == MSS_S_INIT) begin
      mem_wa = init_cnt;
      mem_wd = 1'b0;
    end else if (wr_p1 && mark && (rd_ok || wr_ok)) begin
      mem_wa = wr_lba_p1; // R14
      mem_wd = 1'b0;
    end else if (scan_done && MED_RD_STAT_I == MSS_RD_UNREADABLE && !rd_ok) begin
      mem_wa = scan_ptr; // R13
    end else if (HOST_RD_BAD_I) begin
      mem_wa = HOST_RD_LBA_I; // R13
    end else begin
      mem_we = 1'b0;
    end
  end

  mss_mem #(.AW(LBA_W), .DW(1)) u_marks (
    .clk_i(MCLK_I),
    .we_i(mem_we),
    .waddr_i(mem_wa),
    .wdata_i(mem_wd),
    .re_i(WR_CMD_I),
    .raddr_i(WR_LBA_I),
    .rdata_o(mark)
  );

  // Write lookup pipeline
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      wr_p1 <= 1'b0;
      wr_lba_p1 <= '0;
    end else begin
      wr_p1 <= WR_CMD_I;
      wr_lba_p1 <= WR_LBA_I;
    end
  end
  assign wr_scanned = first_done || (wr_lba_p1 < scan_ptr);

  // Write disposition
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      WR_DONE_O <= 1'b0;
      WR_VERIFY_O <= 1'b0;
      WR_DAR_O <= 1'b0;
      WR_ERR_O <= 1'b0;
    end else begin
      WR_DONE_O <= wr_p1;
      WR_DAR_O <= wr_p1 && mark && (rd_ok || wr_ok); // R14
      WR_ERR_O <= wr_p1 && mark && !ctrl[`MSS_C_AUTO_READ_REALLOCATE_ENABLE] && !ctrl[`MSS_C_AUTO_WRITE_REALLOCATE_ENABLE]; // R15
      WR_VERIFY_O <= wr_p1 && ((prescan && !wr_scanned) || (mark && (rd_ok || wr_ok))); // R10
    end
  end

  // Remap and rewrite requests
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      REMAP_O <= 1'b0;
      REMAP_LBA_O <= '0;
      RWR_O <= 1'b0;
      RWR_LBA_O <= '0;
    end else begin
      REMAP_O <= (VFY_FAIL_I && wr_ok) || scan_realloc; // R14 R17 R8
      if (VFY_FAIL_I && wr_ok) begin
        REMAP_LBA_O <= VFY_LBA_I;
      end else if (scan_realloc) begin
        REMAP_LBA_O <= scan_ptr;
      end
      RWR_O <= IDLE_VERIFY_AFTER_WRITE_DONE_I && IDLE_VERIFY_AFTER_WRITE_MISMATCH_I; // R17
      RWR_LBA_O <= IDLE_VERIFY_AFTER_WRITE_LBA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      a_wr <= 1'b0;
      a_rd <= 1'b0;
      a_addr <= 8'h00;
    end else if (HREADY_I) begin
      a_wr <= HSEL_I && HTRANS_I[1] && HWRITE_I;
      a_rd <= HSEL_I && HTRANS_I[1] && !HWRITE_I;
      a_addr <= HADDR_I[7:0];
    end
  end

  // Static control bits
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      ctrl <= `MSS_CTRL_RST;
    end else if (a_wr && mss_hit(a_addr, `MSS_OFF_CTRL)) begin
      ctrl <= HWDATA_I[`MSS_CTRL_W-1:0];
    end
  end

  // Events, sticky status, mask
  assign ev = {REMAP_O, WR_ERR_O, prescan && hours >= `MSS_PRESCAN_HOURS,
               scan_bad && !rd_ok, scan_done && scan_ptr == {LBA_W{1'b1}}};
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      istat <= `MSS_EV_ZERO;
      imask <= `MSS_EV_ZERO;
    end else begin
      if (a_wr && mss_hit(a_addr, `MSS_OFF_ISTAT)) begin
        istat <= (istat & ~HWDATA_I[`MSS_EV_W-1:0]) | ev;
      end else begin
        istat <= istat | ev;
      end
      if (a_wr && mss_hit(a_addr, `MSS_OFF_IMASK)) begin
        imask <= HWDATA_I[`MSS_EV_W-1:0];
      end
    end
  end
  assign INT_O = |(istat & imask);

  // Read data multiplexer
  always_comb begin
    rd_mux = 32'h00000000;
    if (mss_hit(HADDR_I[7:0], `MSS_OFF_CTRL)) begin
      rd_mux[`MSS_CTRL_W-1:0] = ctrl;
      rd_mux[`MSS_C_PRESCAN] = prescan;
      rd_mux[`MSS_C_FIRST_DONE] = first_done;
    end else if (mss_hit(HADDR_I[7:0], `MSS_OFF_STATUS)) begin
      rd_mux[2:0] = state;
      rd_mux[3] = prescan;
      rd_mux[4] = first_done;
      rd_mux[12:8] = hours;
    end else if (mss_hit(HADDR_I[7:0], `MSS_OFF_SCANPTR)) begin
      rd_mux[LBA_W-1:0] = scan_ptr;
    end else if (mss_hit(HADDR_I[7:0], `MSS_OFF_LOGLBA)) begin
      rd_mux[LBA_W-1:0] = log_lba;
    end else if (mss_hit(HADDR_I[7:0], `MSS_OFF_ISTAT)) begin
      rd_mux[`MSS_EV_W-1:0] = istat;
    end else if (mss_hit(HADDR_I[7:0], `MSS_OFF_IMASK)) begin
      rd_mux[`MSS_EV_W-1:0] = imask;
    end
  end

  // Read data register, loaded in the address phase
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      HRDATA_O <= rd_mux;
    end
  end
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  scan_stop_a: assert property (HOST_BUSY_I && !MED_RECOV_I |-> !MED_RD_REQ_O) // R5
    else $error("scan read not stopped for host");
  recov_hold_a: assert property (state == MSS_S_READ && MED_RECOV_I |=> state == MSS_S_READ) // R6
    else $error("scan left during own recovery");
  first_ovh_a: assert property (state == MSS_S_READ && HOST_BUSY_I && !MED_RECOV_I
                                |=> state == MSS_S_RET && !HOST_GO_O) // R7
    else $error("first host command not held for overhead");
  later_cmd_a: assert property (state == MSS_S_IDLE && HOST_BUSY_I |-> HOST_GO_O) // R7
    else $error("later host command delayed");
  burst_len_a: assert property (state == MSS_S_READ && !MED_RECOV_I
                                |-> (tmr <= `MSS_BURST_MS) || $past(MED_RECOV_I)) // R4
    else $error("scan burst too long");
  prescan_to_a: assert property (prescan && hours >= `MSS_PRESCAN_HOURS |=> !prescan) // R12
    else $error("pre-scan not stopped at hour limit");
  wr_verify_a: assert property (wr_p1 && prescan && !wr_scanned |=> WR_DONE_O && WR_VERIFY_O) // R10
    else $error("unscanned write not verified");
  dar_err_a: assert property (wr_p1 && mark && !ctrl[`MSS_C_AUTO_READ_REALLOCATE_ENABLE] && !ctrl[`MSS_C_AUTO_WRITE_REALLOCATE_ENABLE]
                              |=> WR_ERR_O && !WR_DAR_O) // R15
    else $error("marked write without enables not refused");
  idle_gate_a: assert property ($rose(state == MSS_S_READ) |-> $past(!HOST_BUSY_I)) // R19
    else $error("scan started while host busy");
  rc_block_a: assert property (REMAP_O && !$past(VFY_FAIL_I) |-> !$past(ctrl[`MSS_C_RC])) // R18
    else $error("reallocation with continuous-read set");
  start_dly_a: assert property (state == MSS_S_IDLE ##1 state == MSS_S_READ
                                |-> $past(idle_ms) >= $past(start_dly)) // R2
    else $error("scan started before idle delay");

  host_int_c: cover property (state == MSS_S_RET ##1 state == MSS_S_IDLE);
  pass_c: cover property (scan_done && scan_ptr == {LBA_W{1'b1}});
  dar_wr_c: cover property (wr_p1 && mark ##1 WR_DAR_O);
  idle_verify_after_write_c: cover property (IDLE_VERIFY_AFTER_WRITE_DONE_I && IDLE_VERIFY_AFTER_WRITE_MISMATCH_I ##1 RWR_O);
endmodule : mss_scheduler

// file: hdl/mss_defines.svh
// Constants for the media scan scheduler: times, offsets, bit positions
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH
// Times in milliseconds, counted in millisecond ticks; the pre-scan limit and hours ceiling are in power-on hours
`define MSS_START_FIRST_MS 10'h005
`define MSS_START_LATER_MS 10'h1F4
`define MSS_START_NOW_MS 10'h000
`define MSS_BURST_MS 10'h320
`define MSS_SUSP_MS 10'h064
`define MSS_OVH_MS 10'h001
`define MSS_IDLE_MAX_MS 10'h3FF
`define MSS_PRESCAN_HOURS 5'h18
`define MSS_HOURS_MAX 5'h1F
// Register offsets
`define MSS_OFF_CTRL 8'h00
`define MSS_OFF_STATUS 8'h04
`define MSS_OFF_SCANPTR 8'h08
`define MSS_OFF_LOGLBA 8'h0C
`define MSS_OFF_ISTAT 8'h10
`define MSS_OFF_IMASK 8'h14
// Control bits
`define MSS_C_SCAN_EN 0
`define MSS_C_AUTO_READ_REALLOCATE_ENABLE 2
`define MSS_C_AUTO_WRITE_REALLOCATE_ENABLE 3
`define MSS_C_RC 4
`define MSS_C_IDLE_VERIFY_AFTER_WRITE_EN 5
`define MSS_C_PRESCAN 1
`define MSS_C_FIRST_DONE 6
`define MSS_CTRL_W 6
`define MSS_CTRL_RST 6'h2D
// Interrupt event bits
`define MSS_EV_PASS 0
`define MSS_EV_LOG 1
`define MSS_EV_PRE_TO 2
`define MSS_EV_DAR_ERR 3
`define MSS_EV_REMAP 4
`define MSS_EV_W 5
`define MSS_EV_ZERO 5'h00
`endif

// file: hdl/mss_pkg.sv
// Types for the media scan scheduler
package mss_pkg;
  typedef enum logic [2:0] {
    MSS_S_INIT = 3'h0,
    MSS_S_IDLE = 3'h1,
    MSS_S_READ = 3'h2,
    MSS_S_SUSP = 3'h3,
    MSS_S_RET = 3'h4
  } mss_state_t;
  typedef enum logic [1:0] {
    MSS_RD_OK = 2'h0,
    MSS_RD_RECOVERED = 2'h1,
    MSS_RD_UNREADABLE = 2'h2
  } mss_rd_stat_t;
endpackage : mss_pkg

// file: hdl/mss_mem.sv
// Block mark memory with registered read data
`timescale 1ns/100ps
module mss_mem #(
  parameter int AW = 10,
  parameter int DW = 1
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read
  always_ff @(posedge clk_i) begin
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : mss_mem

// file: verification/mss_media_model.sv
// Behavioural media channel that answers scan reads after a set delay
`timescale 1ns/100ps
module mss_media_model #(
  parameter int LBA_W = 4,
  parameter logic [LBA_W-1:0] BAD_LBA = 4'h7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Scan read request
  input wire logic rd_req_i,
  input wire logic [LBA_W-1:0] lba_i,
  input wire logic [15:0] delay_i,
  // Read completion
  output logic rd_done_o,
  output logic [1:0] rd_stat_o
);
  logic [15:0] cnt;
  logic fire;
  assign fire = rd_req_i && !rd_done_o && (cnt >= delay_i);
  // Read time; an abandoned read starts over
  always_ff @(posedge clk_i) begin
    if (rst_i || !rd_req_i || rd_done_o) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  // Done pulse; status is junk outside the pulse
  always_ff @(posedge clk_i) begin
    rd_done_o <= !rst_i && fire;
    if (fire) begin
      rd_stat_o <= (lba_i == BAD_LBA) ? 2'h2 : 2'h0;
    end else begin
      rd_stat_o <= cnt[1:0] ^ 2'h3;
    end
  end
endmodule : mss_media_model

// file: verification/mss_scheduler_tb.sv
// Self-checking bench for the media scan scheduler
`timescale 1ns/100ps
module mss_scheduler_tb;
  localparam int MS = 20;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, mstat;
  logic busy = 1, wr_cmd = 0, rd_bad = 0, recov = 0, vfail = 0, pend = 0, idone = 0, imis = 0;
  logic [3:0] wr_lba = 0, bad_lba = 0, vlba = 0, ilba = 0, mlba, rmp_lba, rwr_lba, last_rmp, last_rwr;
  logic [15:0] mdly = 16'h0002;
  logic req, mdone, wdone, wver, wdar, werr, go, iro, rmp, rwr, irq, hresp;
  int num_errors = 0, checks = 0, n;
  ////////////////////////////////////////////////////////////////////////
  // Clock, design, partner and pulse capture
  always #25 clk = !clk;
  mss_scheduler #(.LBA_W(4), .CYC_PER_MS(MS), .MS_PER_HOUR(10)) u_dut (
    .MCLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .INT_O(irq),
    .HOST_BUSY_I(busy), .HOST_GO_O(go), .WR_CMD_I(wr_cmd), .WR_LBA_I(wr_lba),
    .WR_DONE_O(wdone), .WR_VERIFY_O(wver), .WR_DAR_O(wdar), .WR_ERR_O(werr),
    .HOST_RD_BAD_I(rd_bad), .HOST_RD_LBA_I(bad_lba), .MED_RD_REQ_O(req), .MED_LBA_O(mlba),
    .MED_RD_DONE_I(mdone), .MED_RD_STAT_I(mstat), .MED_RECOV_I(recov), .VFY_FAIL_I(vfail),
    .VFY_LBA_I(vlba), .REMAP_O(rmp), .REMAP_LBA_O(rmp_lba), .IDLE_VERIFY_AFTER_WRITE_PEND_I(pend),
    .IDLE_VERIFY_AFTER_WRITE_RD_O(iro), .IDLE_VERIFY_AFTER_WRITE_DONE_I(idone), .IDLE_VERIFY_AFTER_WRITE_MISMATCH_I(imis), .IDLE_VERIFY_AFTER_WRITE_LBA_I(ilba),
    .RWR_O(rwr), .RWR_LBA_O(rwr_lba));
  mss_media_model #(.LBA_W(4), .BAD_LBA(4'h7)) u_media (.clk_i(clk), .rst_i(srst),
    .rd_req_i(req), .lba_i(mlba), .delay_i(mdly), .rd_done_o(mdone), .rd_stat_o(mstat));
  always @(posedge clk) begin
    if (rmp) last_rmp <= rmp_lba;
    if (rwr) last_rwr <= rwr_lba;
  end
  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rng(input int v, input int lo, input int hi);
    chk(v, (v >= lo && v <= hi) ? v : lo);
  endtask : rng
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clk); while (hready !== 1);
    hsel <= 0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hready !== 1);
    rd = hrdata;
  endtask : ahb
  task automatic lk(input logic [3:0] lba, input logic [2:0] exp);
    int k;
    @(posedge clk) wr_cmd <= 1; wr_lba <= lba;
    @(posedge clk) wr_cmd <= 0;
    k = 0;
    do begin @(posedge clk); k++; end while (wdone !== 1 && k < 5);
    chk(k, 2);
    chk({wver, wdar, werr}, exp);
  endtask : lk
  task automatic wreq(input logic lvl);
    n = 0;
    while (req !== lvl && n < 30000) begin @(posedge clk); n++; end
  endtask : wreq
  task automatic pulse1(input int sel);
    @(posedge clk);
    case (sel)
      0: rd_bad <= 1;
      1: vfail <= 1;
      default: idone <= 1;
    endcase
    @(posedge clk) {rd_bad, vfail, idone} <= 3'b000;
    repeat (3) @(posedge clk);
  endtask : pulse1
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    ahb(0, 8'h00, 0); chk(rd & 32'h3D, 32'h2D);
    ahb(0, 8'h04, 0); chk(rd[3], 1);
    ahb(0, 8'h18, 0); chk(rd, 0);
    chk(hresp, 0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_prescan();
    lk(4'h9, 3'b100);
    ahb(1, 8'h14, 32'h1);
    @(posedge clk) busy <= 0;
    wreq(1); rng(n, 0, 25);
    n = 0;
    while (irq !== 1 && n < 3000) begin @(posedge clk); n++; end
    @(posedge clk) busy <= 1;
    chk(irq, 1);
    chk(last_rmp, 4'h7);
    ahb(0, 8'h0C, 0); chk(rd, 32'h7);
    ahb(0, 8'h04, 0); chk(rd[4:3], 2'b10);
    lk(4'h9, 3'b000);
    ahb(1, 8'h14, 0); ahb(0, 8'h10, 0); chk({irq, rd[0]}, 2'b01);
    ahb(1, 8'h14, 1); ahb(1, 8'h10, 1); ahb(0, 8'h10, 0); chk({irq, rd[0]}, 2'b00);
    $display("test prescan done");
  endtask : t_prescan
  task automatic t_timing();
    @(posedge clk) mdly <= 16'd4000;
    @(posedge clk) busy <= 0;
    wreq(1); rng(n, 499 * MS - 2, 500 * MS + 4);
    wreq(0); rng(n, 799 * MS - 2, 800 * MS + 4);
    wreq(1); rng(n, 99 * MS - 2, 100 * MS + 4);
    $display("test timing done");
  endtask : t_timing
  task automatic t_yield();
    @(posedge clk) busy <= 1; recov <= 1;
    repeat (3) @(posedge clk);
    #1 chk({req, go}, 2'b10);
    @(posedge clk) recov <= 0;
    #1 chk(req, 0);
    n = 0;
    while (go !== 1 && n < 200) begin @(posedge clk); n++; end
    rng(n, 1, 2 * MS + 4);
    @(posedge clk) busy <= 0;
    @(posedge clk) busy <= 1;
    #1 chk(go, 1);
    ahb(1, 8'h00, 32'h2C);
    $display("test yield done");
  endtask : t_yield
  task automatic t_dar();
    bad_lba <= 4'h5; pulse1(0);
    lk(4'h5, 3'b110);
    vlba <= 4'h5; pulse1(1);
    chk(last_rmp, 4'h5);
    lk(4'h5, 3'b000);
    bad_lba <= 4'h6; pulse1(0);
    ahb(1, 8'h00, 32'h3C);
    lk(4'h6, 3'b000);
    ahb(1, 8'h00, 32'h20);
    lk(4'h6, 3'b001);
    ahb(0, 8'h10, 0); chk(rd[3], 1);
    $display("test dar done");
  endtask : t_dar
  task automatic t_idle_verify_after_write();
    @(posedge clk) busy <= 0; pend <= 1;
    repeat (2) @(posedge clk);
    #1 chk(iro, 1);
    @(posedge clk) busy <= 1;
    #1 chk(iro, 0);
    @(posedge clk) busy <= 0; imis <= 1; ilba <= 4'h3;
    pulse1(2);
    chk(last_rwr, 4'h3);
    $display("test idle_verify_after_write done");
  endtask : t_idle_verify_after_write
  task automatic t_reset();
    @(posedge clk) busy <= 1; srst <= 1;
    repeat (4) @(posedge clk);
    srst <= 0;
    repeat (20) @(posedge clk);
    ahb(0, 8'h04, 0); chk(rd[4:3], 2'b01);
    ahb(0, 8'h08, 0); chk(rd, 0);
    repeat (25 * 10 * MS) @(posedge clk);
    ahb(0, 8'h04, 0); chk(rd[3], 0);
    rng(rd[12:8], 24, 31);
    ahb(0, 8'h10, 0); chk(rd[2], 1);
    @(posedge clk) busy <= 0;
    wreq(1); rng(n, 4 * MS - 2, 5 * MS + 4);
    @(posedge clk) busy <= 1;
    $display("test reset done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    repeat (20) @(posedge clk);
    t_regs();
    t_prescan();
    t_timing();
    t_yield();
    t_dar();
    t_idle_verify_after_write();
    t_reset();
    final_report();
  end
  initial begin
    #(60000 * 50);
    num_errors++;
    final_report();
  end
endmodule : mss_scheduler_tb
